// ---- laac_acq.sv ----
// acquisition controller top: registers, capture path, memory bus multiplexer
`timescale 1ns/1ps
`include "laac_defs.svh"
module laac_acq
(
  input wire logic mclk, // 20 MHz base clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [2:0] reg_addr, // register index
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic [17:0] host_addr, // host memory address
  input wire logic [15:0] host_wdata, // host memory write data
  input wire logic host_mem_rd, // host memory read strobe
  input wire logic host_mem_wr, // host memory write strobe
  output logic [15:0] host_rdata, // memory data returned to host
  input wire logic [7:0] probe_in, // analyzer inputs, asynchronous
  output logic [17:0] mem_addr, // shared memory address bus
  output logic [15:0] mem_dout, // memory data out
  output logic mem_doe, // memory data output enable
  input wire logic [15:0] mem_din, // memory data in
  output logic mem_we, // memory write strobe
  output logic mem_oe, // memory read enable
  output logic run // acquire bit
);
  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic [15:0] rate_q;
  logic [11:0] post_q;
  laac_pkg::laac_trig_t trig_q;
  logic [5:0] bank_q;
  logic run_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] input_level_latch;
  logic [7:0] ping_q;
  logic [12:0] cap_cnt_q;
  logic [11:0] post_cnt_q;
  logic [11:0] trig_addr_q;
  logic trig_seen_q;
  logic done_q;
  logic [15:0] word_q;
  logic word_we_q;
  logic [11:0] word_addr_q;
  logic [15:0] rdata_q;
  logic [15:0] host_rdata_q;
  laac_pkg::laac_state_t state_q;
  logic sample_tick;
  logic hit;
  logic wr_rate;
  logic wr_post;
  logic wr_trig;
  logic wr_cmd;
  logic start;
  logic stop;
  logic post_done;
  logic [11:0] mem_addr_word;
  logic mem_addr_lsb;
  logic [15:0] rd_mux;
  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  // configuration registers only change while idle so a capture keeps its setup
  assign wr_rate = reg_wr && reg_addr == `LAAC_REG_RATE && !run_q;
  assign wr_post = reg_wr && reg_addr == `LAAC_REG_POST && !run_q;
  assign wr_trig = reg_wr && reg_addr == `LAAC_REG_TRIG && !run_q;
  assign wr_cmd = reg_wr && reg_addr == `LAAC_REG_CMD;
  assign start = wr_cmd && reg_wdata[`LAAC_CMD_RUN_BIT] && !run_q;
  assign stop = wr_cmd && !reg_wdata[`LAAC_CMD_RUN_BIT];
  assign post_done = state_q == laac_pkg::LAAC_POST && sample_tick && post_cnt_q == 12'h000;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rate_q <= `LAAC_RATE_RST;
      post_q <= `LAAC_POST_RST;
      trig_q <= `LAAC_TRIG_RST;
      bank_q <= 6'h00;
    end
    else
    begin
      if (wr_rate)
        rate_q <= reg_wdata;
      if (wr_post)
        post_q <= reg_wdata[11:0];
      if (wr_trig)
        trig_q <= reg_wdata;
      if (wr_cmd && !run_q)
        bank_q <= reg_wdata[5:0];
    end
  end
  // status reads stay live during a capture
  assign rd_mux = (reg_addr == `LAAC_REG_STATUS) ? {13'h0000, trig_seen_q, done_q, run_q} :
                  (reg_addr == `LAAC_REG_TRIG_ADDR) ? {4'h0, trig_addr_q} :
                  (reg_addr == `LAAC_REG_LEVELS) ? {8'h00, input_level_latch} :
                  (reg_addr == `LAAC_REG_CMD) ? {run_q, 9'h000, bank_q} :
                  16'h0000;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_q <= 16'h0000;
    else
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
  end
  assign reg_rdata = rdata_q;
  // ---------------------------------------------------------------------------
  // acquisition state
  // ---------------------------------------------------------------------------
  // software stop and the end of the post count both drop the acquire bit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_q <= laac_pkg::LAAC_IDLE;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        laac_pkg::LAAC_IDLE:
        begin
          if (start)
          begin
            state_q <= laac_pkg::LAAC_ARMED;
            run_q <= 1'b1;
            done_q <= 1'b0;
          end
        end
        laac_pkg::LAAC_ARMED:
        begin
          if (stop)
          begin
            state_q <= laac_pkg::LAAC_IDLE;
            run_q <= 1'b0;
          end
          else if (sample_tick && hit)
            state_q <= laac_pkg::LAAC_POST;
        end
        laac_pkg::LAAC_POST:
        begin
          if (stop || post_done)
          begin
            state_q <= laac_pkg::LAAC_IDLE;
            run_q <= 1'b0;
            done_q <= post_done;
          end
        end
        default:
        begin
          state_q <= laac_pkg::LAAC_IDLE;
          run_q <= 1'b0;
        end
      endcase
    end
  end
  assign run = run_q;
  laac_rate_gen u_rate
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(run_q),
    .rate(rate_q),
    .sample_tick(sample_tick)
  );
  laac_trig_match u_match
  (
    .sample(sync2_q),
    .trig(trig_q),
    .hit(hit)
  );
  // ---------------------------------------------------------------------------
  // input path
  // ---------------------------------------------------------------------------
  // two flops before any use; the level latch is free-running for display
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      input_level_latch <= 8'h00;
    end
    else
    begin
      sync1_q <= probe_in;
      sync2_q <= sync1_q;
      input_level_latch <= sync2_q;
    end
  end
  // ---------------------------------------------------------------------------
  // capture counters and ping-pong pairing
  // ---------------------------------------------------------------------------
  // bit zero picks the latch; a full pair is written while the next sample comes
  always_ff @(posedge mclk)
  begin
    if (sys_rst || start)
    begin
      cap_cnt_q <= 13'h0000;
      ping_q <= 8'h00;
      word_q <= 16'h0000;
      word_we_q <= 1'b0;
      word_addr_q <= 12'h000;
    end
    else
    begin
      word_we_q <= 1'b0;
      if (run_q && sample_tick)
      begin
        cap_cnt_q <= cap_cnt_q + 13'h0001;
        if (!cap_cnt_q[0])
          ping_q <= sync2_q;
        else
        begin
          word_q <= {sync2_q, ping_q};
          word_we_q <= 1'b1;
          word_addr_q <= cap_cnt_q[12:1];
        end
      end
    end
  end
  // counter bit one drives the memory address lsb, one word per pair
  assign mem_addr_word = word_addr_q;
  assign mem_addr_lsb = mem_addr_word[0];
  // post-trigger counter holds until a match, then counts samples
  always_ff @(posedge mclk)
  begin
    if (sys_rst || start)
    begin
      post_cnt_q <= post_q;
      trig_addr_q <= sys_rst ? 12'h000 : trig_addr_q;
      trig_seen_q <= 1'b0;
    end
    else if (state_q == laac_pkg::LAAC_ARMED && sample_tick && hit)
    begin
      trig_addr_q <= cap_cnt_q[12:1];
      trig_seen_q <= 1'b1;
    end
    else if (state_q == laac_pkg::LAAC_POST && sample_tick && post_cnt_q != 12'h000)
      post_cnt_q <= post_cnt_q - 12'h001;
  end
  // ---------------------------------------------------------------------------
  // memory bus multiplexer
  // ---------------------------------------------------------------------------
  // host sees no memory at all while acquiring
  assign mem_addr = run_q ? {bank_q, mem_addr_word[11:1], mem_addr_lsb} : host_addr;
  assign mem_dout = run_q ? word_q : host_wdata;
  assign mem_doe = run_q ? 1'b1 : host_mem_wr;
  assign mem_we = run_q ? word_we_q : host_mem_wr;
  assign mem_oe = !run_q && host_mem_rd && !host_mem_wr;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      host_rdata_q <= 16'h0000;
    else if (mem_oe)
      host_rdata_q <= mem_din;
  end
  assign host_rdata = host_rdata_q;
  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_addr_mux;
    @(posedge mclk) disable iff (sys_rst)
      !run_q |-> mem_addr == host_addr && !mem_doe == !host_mem_wr;
  endproperty
  a_addr_mux: assert property (p_addr_mux) else $error("host lost bus while idle");
  property p_no_host;
    @(posedge mclk) disable iff (sys_rst)
      run_q |-> !mem_oe && mem_we == word_we_q;
  endproperty
  a_no_host: assert property (p_no_host) else $error("host reached memory in capture");
  property p_bank;
    @(posedge mclk) disable iff (sys_rst)
      run_q |-> mem_addr[17:12] == bank_q;
  endproperty
  a_bank: assert property (p_bank) else $error("bank lines wrong");
  property p_status;
    @(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == `LAAC_REG_STATUS) |=> reg_rdata[0] == $past(run_q);
  endproperty
  a_status: assert property (p_status) else $error("status unreadable");
  property p_trig_store;
    @(posedge mclk) disable iff (sys_rst)
      (state_q == laac_pkg::LAAC_ARMED && sample_tick && hit && !stop)
        |=> trig_addr_q == $past(cap_cnt_q[12:1]) && state_q == laac_pkg::LAAC_POST;
  endproperty
  a_trig_store: assert property (p_trig_store) else $error("trigger address lost");
  property p_post_freeze;
    @(posedge mclk) disable iff (sys_rst)
      (state_q == laac_pkg::LAAC_ARMED && !start) |=> $stable(post_cnt_q);
  endproperty
  a_post_freeze: assert property (p_post_freeze) else $error("post count moved early");
  property p_end;
    @(posedge mclk) disable iff (sys_rst)
      post_done |=> !run_q && done_q;
  endproperty
  a_end: assert property (p_end) else $error("capture did not end");
  sequence s_pair;
    run_q && sample_tick && cap_cnt_q[0] && !start;
  endsequence
  property p_pair;
    @(posedge mclk) disable iff (sys_rst)
      s_pair |=> word_we_q && word_q[15:8] == $past(sync2_q) && word_q[7:0] == $past(ping_q);
  endproperty
  a_pair: assert property (p_pair) else $error("pair word wrong");
  // the word address is the sample count without its bit zero
  property p_word_addr;
    @(posedge mclk) disable iff (sys_rst)
      s_pair |=> word_addr_q == $past(cap_cnt_q[12:1]);
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("pair address not from bit one");
  // apart from its clear on start, the address counter only moves on a sample while acquiring
  property p_cnt_hold;
    @(posedge mclk) disable iff (sys_rst)
      !(run_q && sample_tick) && !start |=> $stable(cap_cnt_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("address counter moved off tick");
  property p_cnt_step;
    @(posedge mclk) disable iff (sys_rst)
      run_q && sample_tick |=> cap_cnt_q == 13'($past(cap_cnt_q) + 13'h0001);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("address counter missed a tick");
  // host strobes alone set the data direction while idle
  property p_host_dir;
    @(posedge mclk) disable iff (sys_rst)
      !run_q |-> (host_mem_wr ? (mem_doe && !mem_oe) : (mem_oe == host_mem_rd && !mem_doe));
  endproperty
  a_host_dir: assert property (p_host_dir) else $error("host bus direction wrong");
  // during capture the controller drives the packed word out
  property p_cap_data;
    @(posedge mclk) disable iff (sys_rst)
      run_q |-> mem_doe && mem_dout == word_q;
  endproperty
  a_cap_data: assert property (p_cap_data) else $error("capture data not on bus");
  property p_levels;
    @(posedge mclk) disable iff (sys_rst)
      !$past(sys_rst) |-> input_level_latch == $past(sync2_q);
  endproperty
  a_levels: assert property (p_levels) else $error("level latch not following inputs");
  // the rate setup may not change under a running capture
  property p_rate_hold;
    @(posedge mclk) disable iff (sys_rst)
      run_q |=> $stable(rate_q);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed during capture");
  property p_post_step;
    @(posedge mclk) disable iff (sys_rst)
      (state_q == laac_pkg::LAAC_POST && sample_tick && post_cnt_q != 12'h000 && !stop)
        |=> post_cnt_q == 12'($past(post_cnt_q) - 12'h001);
  endproperty
  a_post_step: assert property (p_post_step) else $error("post count not stepping");
endmodule // laac_acq

// ---- laac_defs.svh ----
// constants for the logic analyzer acquisition controller
`ifndef LAAC_DEFS_SVH
`define LAAC_DEFS_SVH
// -----------------------------------------------------------------------------
// register offsets (register index on the command port)
// -----------------------------------------------------------------------------
`define LAAC_REG_RATE 3'h0
`define LAAC_REG_POST 3'h1
`define LAAC_REG_TRIG 3'h2
`define LAAC_REG_CMD 3'h3
`define LAAC_REG_STATUS 3'h4
`define LAAC_REG_TRIG_ADDR 3'h5
`define LAAC_REG_LEVELS 3'h6
// -----------------------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------------------
`define LAAC_RATE_SLOW_BIT 15
`define LAAC_RATE_HALF_BIT 13
`define LAAC_RATE_QUARTER_BIT 14
`define LAAC_CMD_RUN_BIT 15
`define LAAC_RATE_RST 16'h0000
`define LAAC_POST_RST 12'h000
`define LAAC_TRIG_RST 16'h0000
`define LAAC_CMD_RST 16'h0000
`define LAAC_BANK_W 6
`define LAAC_WORD_ADDR_W 12
`define LAAC_MEM_ADDR_W 18
`endif

// ---- laac_pkg.sv ----
// types for the logic analyzer acquisition controller
package laac_pkg;
  // per-channel trigger condition: low byte is level, high byte is care mask
  typedef struct packed {
    logic [7:0] care;
    logic [7:0] level;
  } laac_trig_t;
  // word and address bound for the trace memory
  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] data;
    logic we;
  } laac_mem_t;
  typedef enum logic [1:0] {LAAC_IDLE, LAAC_ARMED, LAAC_POST} laac_state_t;
endpackage

// ---- laac_rate_gen.sv ----
// sample tick generator from the 20 MHz base clock
`timescale 1ns/1ps
`include "laac_defs.svh"
module laac_rate_gen
(
  input wire logic mclk, // base clock
  input wire logic sys_rst, // synchronous reset
  input wire logic run, // acquisition enabled
  input wire logic [15:0] rate, // sample-rate register
  output logic sample_tick // one-cycle sample enable
);
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic [1:0] div_q;
  logic slow_sel;
  logic half_sel;
  logic quarter_sel;
  logic slow_tick;
  assign slow_sel = rate[`LAAC_RATE_SLOW_BIT];
  assign half_sel = rate[`LAAC_RATE_HALF_BIT];
  assign quarter_sel = rate[`LAAC_RATE_QUARTER_BIT];
  assign slow_tick = run && (cnt_q == 15'h0000);
  // load pre-count, count to zero, reload
  assign cnt_d = (!run || cnt_q == 15'h0000) ? rate[14:0] : cnt_q - 15'h0001;
  // ---------------------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------------------
  // base_clock, base_clock_half and base_clock_quarter become enables, one clock only
  assign sample_tick = !run ? 1'b0 :
                       slow_sel ? slow_tick :
                       quarter_sel ? (div_q == 2'h3) :
                       half_sel ? div_q[0] : 1'b1;
  // divider and slow counter restart with each capture so the phase is fixed
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !run)
    begin
      div_q <= 2'h0;
      cnt_q <= 15'h0000;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      cnt_q <= cnt_d;
    end
  end
  property p_slow_reload;
    @(posedge mclk) disable iff (sys_rst)
      (run && slow_sel && cnt_q == 15'h0000 && $stable(rate)) ##1 run |-> cnt_q == rate[14:0];
  endproperty
  a_slow_reload: assert property (p_slow_reload) else $error("slow count not reloaded");
  property p_quarter;
    @(posedge mclk) disable iff (sys_rst)
      (run && !slow_sel && quarter_sel && sample_tick) |-> ##1 !sample_tick [*3];
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter rate wrong");
endmodule // laac_rate_gen

// ---- laac_trig_match.sv ----
// per-channel trigger comparator
`timescale 1ns/1ps
`include "laac_defs.svh"
module laac_trig_match
(
  input wire logic [7:0] sample, // current sample
  input wire laac_pkg::laac_trig_t trig, // trigger definition
  output logic hit // all cared channels match
);
  logic [7:0] chan_ok;
  // each channel: ignore, or match its programmed level
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_chan
      assign chan_ok[i] = !trig.care[i] || (sample[i] == trig.level[i]);
    end
  endgenerate
  assign hit = &chan_ok;
endmodule // laac_trig_match

// ---- laac_sram_model.sv ----
// behavioural trace memory standing on the shared address and data buses
`timescale 1ns/1ps
module laac_sram_model
(
  input wire logic mclk, // base clock, write sampling
  input wire logic [17:0] mem_addr, // shared address bus
  input wire logic [15:0] mem_dout, // data from the controller
  input wire logic mem_doe, // controller drives the data bus
  input wire logic mem_we, // write strobe
  input wire logic mem_oe, // read enable
  output logic [15:0] mem_din // data back to the controller
);
  // -----------------------------------------------------------------------------
  // storage and bus behaviour
  // -----------------------------------------------------------------------------
  logic [15:0] mem [0:262143];
  logic [15:0] hold_q;
  // a write only lands when the controller really drives the data bus
  always_ff @(posedge mclk)
  begin
    if (mem_we && mem_doe)
      mem[mem_addr] <= mem_dout;
    // released bus toggles so a stale value never looks valid
    hold_q <= mem_oe ? mem[mem_addr] : ~hold_q;
  end
  // reads are asynchronous, as a plain sram
  assign mem_din = mem_oe ? mem[mem_addr] : hold_q;
endmodule // laac_sram_model

// ---- logic_analyzer_acquisition_test.sv ----
// self-checking testbench for the acquisition controller
`timescale 1ns/1ps
`include "laac_defs.svh"
module logic_analyzer_acquisition_test;
  // -----------------------------------------------------------------------------
  // signals and bookkeeping
  // -----------------------------------------------------------------------------
  logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic host_mem_rd = 1'b0, host_mem_wr = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, host_wdata = 16'h0000, v;
  logic [17:0] host_addr = 18'h00000;
  logic [7:0] probe_in = 8'h00, pre_v = 8'h00, post_v = 8'h00;
  logic [15:0] reg_rdata, host_rdata, mem_dout, mem_din;
  logic [17:0] mem_addr;
  logic mem_doe, mem_we, mem_oe, run;
  logic [11:0] last_a = 12'h000;
  logic [5:0] bank = 6'h00;
  logic [31:0] seed = 32'hf1e1, r;
  int num_errors = 0, n_compared = 0, cyc = 0, nwr = 0, lastc = 0, exp_per = 1, i, pc;

  laac_acq u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_mem_rd(host_mem_rd), .host_mem_wr(host_mem_wr),
    .host_rdata(host_rdata), .probe_in(probe_in), .mem_addr(mem_addr), .mem_dout(mem_dout),
    .mem_doe(mem_doe), .mem_din(mem_din), .mem_we(mem_we), .mem_oe(mem_oe), .run(run));
  laac_sram_model u_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_dout(mem_dout),
    .mem_doe(mem_doe), .mem_we(mem_we), .mem_oe(mem_oe), .mem_din(mem_din));

  // -----------------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // a captured byte must be one of the two levels the probes held
  function automatic logic okb(input logic [7:0] b);
    return (b === pre_v) || (b === post_v);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // host memory cycles through the bus multiplexer
  task automatic hwr(input logic [17:0] a, input logic [15:0] d);
    @(posedge mclk) {host_addr, host_wdata, host_mem_wr} <= {a, d, 1'b1};
    #1 chk("host wr addr", a, mem_addr);
    chk("host wr bus", {d, 2'b11}, {mem_dout, mem_doe, mem_we});
    @(posedge mclk) host_mem_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [17:0] a, output logic [15:0] d);
    @(posedge mclk) {host_addr, host_mem_rd} <= {a, 1'b1};
    #1 chk("host rd dir", 2'b01, {mem_doe, mem_oe});
    @(posedge mclk) host_mem_rd <= 1'b0;
    #1 d = host_rdata;
  endtask

  // -----------------------------------------------------------------------------
  // write monitor: spacing, address walk, bank lines and packed data
  // -----------------------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc++;
    if (!sys_rst && run === 1'b1 && mem_we === 1'b1)
    begin
      chk("bank lines", bank, mem_addr[17:12]);
      if (nwr > 0)
      begin
        chk("word addr", 12'(last_a + 12'h001), mem_addr[11:0]);
        chk("write gap", 2 * exp_per, cyc - lastc);
      end
      else
        chk("first addr", 0, mem_addr[11:0]);
      chk("packed word", 1, okb(mem_dout[15:8]) && okb(mem_dout[7:0]));
      nwr++;
      last_a = mem_addr[11:0];
      lastc = cyc;
    end
  end

  // one capture: program, let it run untriggered, then trigger or stop
  task automatic cap(input logic [15:0] rate, input int per, input int pre_cyc,
    input logic [11:0] post, input bit stop);
    logic [7:0] care, lvl;
    logic [15:0] st;
    int d;
    r = xs();
    care = r[7:0] | 8'h01;
    lvl = r[15:8];
    bank = r[21:16];
    r = xs();
    post_v = (r[7:0] & ~care) | (lvl & care);
    pre_v = post_v ^ (care & (~care + 8'h01)); // one cared channel off, the rest matching
    exp_per = per;
    nwr = 0;
    @(posedge mclk) probe_in <= pre_v;
    wr(`LAAC_REG_RATE, rate);
    wr(`LAAC_REG_POST, {4'h0, post});
    wr(`LAAC_REG_TRIG, {care, lvl});
    wr(`LAAC_REG_CMD, {1'b1, 9'h000, bank});
    #1 chk("run start", 1, run);
    @(posedge mclk) {host_addr, host_mem_wr} <= {~bank, 12'h000, 1'b1};
    repeat (pre_cyc) @(posedge mclk);
    #1 chk("host locked out", bank, mem_addr[17:12]);
    // a host read must not open the memory either while the capture owns it
    @(posedge mclk) {host_mem_wr, host_mem_rd} <= 2'b01;
    #1 chk("host read blocked", 0, {mem_oe, mem_doe ^ 1'b1});
    @(posedge mclk) host_mem_rd <= 1'b0;
    rd(`LAAC_REG_STATUS, st);
    chk("status armed", 16'h0001, st);
    if (stop)
    begin
      wr(`LAAC_REG_CMD, 16'h0000);
      #1 chk("stop", 0, run);
    end
    else
    begin
      @(posedge mclk) probe_in <= post_v;
      for (d = 0; d < (post + 8) * per + 40 && run === 1'b1; d++)
        @(posedge mclk);
      #1 chk("run end", 0, run);
      chk("bus back", host_addr, mem_addr);
      rd(`LAAC_REG_STATUS, st);
      chk("status done", 3'b110, st[2:0]);
      rd(`LAAC_REG_TRIG_ADDR, st);
      // trigger to last stored word, offset by two so short post counts stay positive
      d = int'(12'(last_a - st[11:0] + 12'h002)) - int'(post) / 2;
      chk("trig addr", 1, d >= 0 && d <= 4);
    end
    hrd({bank, last_a}, st);
    chk("stored word", 1, okb(st[15:8]) && okb(st[7:0]));
    $display("test capture rate %h stop %0d done", rate, stop);
  endtask

  // -----------------------------------------------------------------------------
  // clock, watchdog and main sequence
  // -----------------------------------------------------------------------------
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  // longest capture walks about 9000 cycles; everything fits well inside 40000
  initial
  begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    $display("FAIL watchdog expected finish seen hang");
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`LAAC_REG_STATUS, v);
    chk("status reset", 16'h0000, v);
    rd(`LAAC_REG_TRIG_ADDR, v);
    chk("trig addr reset", 16'h0000, v);
    rd(3'h7, v);
    chk("unmapped", 16'h0000, v);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      r = xs();
      @(posedge mclk) probe_in <= r[7:0];
      repeat (3) @(posedge mclk);
      rd(`LAAC_REG_LEVELS, v);
      chk("levels", {8'h00, probe_in}, v);
    end
    $display("test levels done");
    for (i = 0; i < 6; i++)
    begin
      r = xs();
      hwr(r[17:0], r[31:16]);
      hrd(r[17:0], v);
      chk("host readback", r[31:16], v);
    end
    $display("test host memory done");
    cap(16'h0000, 1, 9000, 12'd40, 1'b0);
    cap(16'h2000, 2, 100, 12'd7, 1'b0);
    cap(16'h4000, 4, 100, 12'd0, 1'b0);
    cap(16'h6000, 4, 60, 12'd3, 1'b0);
    r = xs();
    pc = int'(r[2:0]) + 2;
    cap(16'h8000 | 16'(pc), pc + 1, 150, 12'd9, 1'b0);
    cap(16'h0000, 1, 50, 12'd5, 1'b1);
    complete_run();
  end
endmodule // logic_analyzer_acquisition_test
